// [src/ppcm_defines.vh]
// ppcm_defines.vh: addresses, field positions and reset values for the
// counter-array pwm cycle and module mode configuration block.
// assumes an 8-bit special-function-register bus with 8-bit addresses.
`ifndef PPCM_DEFINES_VH
`define PPCM_DEFINES_VH

// register addresses
`define PPCM_ADDR_MODE0      8'hDA
`define PPCM_ADDR_MODE1      8'hDB
`define PPCM_ADDR_MODE2      8'hDC
`define PPCM_ADDR_MODE3      8'hDD
`define PPCM_ADDR_MODE4      8'hDE
`define PPCM_ADDR_MODE5      8'hCE
`define PPCM_ADDR_PWMCFG     8'hDF
// compare byte pair addresses, chosen here, low byte then high byte per module
`define PPCM_ADDR_CMPL_BASE  8'hE9
`define PPCM_ADDR_CMPH_BASE  8'hF1

// pwm cycle configuration fields
`define PPCM_BANK_SEL_BIT    7
`define PPCM_WRAP_IE_BIT     6
`define PPCM_WRAP_FLAG_BIT   5
`define PPCM_CLSEL_HI        1
`define PPCM_CLSEL_LO        0
`define PPCM_PWMCFG_WMASK    8'hE3

// module mode fields
`define PPCM_WIDE_BIT        7
`define PPCM_TOGGLE_BIT      2
`define PPCM_PULSE_BIT       1

// reset values
`define PPCM_MODE_RESET      8'h00
`define PPCM_PWMCFG_RESET    8'h00
`define PPCM_CMP_RESET       16'h0000

// cycle length codes
`define PPCM_CLSEL_8         2'h0
`define PPCM_CLSEL_9         2'h1
`define PPCM_CLSEL_10        2'h2
`define PPCM_CLSEL_11        2'h3

`define PPCM_NUM_MODULES     6

`endif

// [src/ppcm_cmp_mem.v]
// ppcm_cmp_mem.v: small storage for the six 16-bit compare words, written by software or by reload.
// one byte write port and one registered read port; one clock.
`timescale 1ns/100ps
`include "ppcm_defines.vh"

module ppcm_cmp_mem (
	// clock and reset
	input  wire        clk_sys,
	input  wire        reset,
	// byte write port
	input  wire        wr_en,
	input  wire        wr_high,
	input  wire [2:0]  wr_index,
	input  wire [7:0]  wr_data,
	// registered read port, whole word
	input  wire [2:0]  rd_index,
	output reg  [15:0] rd_data_q,
	// flat view of all words for the compare datapath
	output wire [95:0] all_words
);

	reg [15:0] mem_q [0:5];
	integer    i;

	// flat view for the per-module logic
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_flat
			assign all_words[g*16 +: 16] = mem_q[g];
		end
	endgenerate

	// byte writes; reset clears so compare values are defined
	always @(posedge clk_sys) begin
		if (reset) begin
			for (i = 0; i < 6; i = i + 1)
				mem_q[i] <= `PPCM_CMP_RESET;
		end else if (wr_en && (wr_index < 3'h6)) begin
			if (wr_high)
				mem_q[wr_index][15:8] <= wr_data;
			else
				mem_q[wr_index][7:0] <= wr_data;
		end
	end

	// read data come from a register
	always @(posedge clk_sys) begin
		if (reset)
			rd_data_q <= `PPCM_CMP_RESET;
		else if (rd_index < 3'h6)
			rd_data_q <= mem_q[rd_index];
		else
			rd_data_q <= `PPCM_CMP_RESET;
	end

endmodule // ppcm_cmp_mem

// [src/ppcm_wrap_det.v]
// ppcm_wrap_det.v: detects the end of a pwm cycle from the main counter.
// assumes main_counter and its advance strobe are synchronous to clk_sys.
`timescale 1ns/100ps
`include "ppcm_defines.vh"

module ppcm_wrap_det (
	// clock and reset
	input  wire        clk_sys,
	input  wire        reset,
	// counter view
	input  wire [15:0] main_counter,
	input  wire        counter_tick,
	input  wire [1:0]  cycle_length_select,
	// one-cycle pulse as the selected bit carries out
	output wire        cycle_wrap_pulse,
	// one-cycle pulse as bit 15 carries out
	output wire        wide_wrap_pulse
);

	reg [1:0] tick_d1_q;

	// mask of the counter bits up to and including the selected carry bit
	function [10:0] ppcm_len_mask;
		input [1:0] sel;
		begin
			case (sel)
				`PPCM_CLSEL_8:  ppcm_len_mask = 11'h0FF;
				`PPCM_CLSEL_9:  ppcm_len_mask = 11'h1FF;
				`PPCM_CLSEL_10: ppcm_len_mask = 11'h3FF;
				default:        ppcm_len_mask = 11'h7FF;
			endcase
		end
	endfunction

	// counter is all ones in the low field on a tick: this tick carries out
	wire at_top_w  = ((main_counter[10:0] & ppcm_len_mask(cycle_length_select))
	                  == ppcm_len_mask(cycle_length_select));
	wire at_wide_w = (main_counter == 16'hFFFF);

	// register the carry so the pulse aligns with the counter rolling over
	always @(posedge clk_sys) begin
		if (reset) begin
			tick_d1_q <= 2'h0;
		end else begin
			tick_d1_q <= {counter_tick & at_wide_w, counter_tick & at_top_w};
		end
	end

	assign cycle_wrap_pulse = tick_d1_q[0];
	assign wide_wrap_pulse  = tick_d1_q[1];

endmodule // ppcm_wrap_det

// [src/ppcm_pwm_cfg.v]
// ppcm_pwm_cfg.v: pwm cycle and module mode configuration for the
// programmable counter array, with compare/reload banks and match outputs.
// assumes a synchronous sfr bus: address, write strobe and read strobe
// valid for one clk_sys cycle; read data registered two cycles later.
//
// Contract
// - bank-select bit 7 steers compare byte accesses to compare or reload words
// - reload words only act in 9, 10 and 11-bit cycle lengths
// - bank select 0 reaches compare pair, 1 reaches reload pair
// - wrap flag requests interrupt only while enable bit 6 is set
// - wrap flag sets on carry out of selected bit 7 to 10
// - wrap flag at bit 5 set by hardware or software, cleared only by software
// - bits 4 to 2 of cycle config read zero, writes ignored
// - selector codes 00 to 11 give 8, 9, 10, 11-bit cycles
// - one shared cycle length governs all non-wide pwm modules
// - wide pwm modules ignore the cycle length selector
// - six 8-bit mode registers, read/write, reset to zero
// - wide bit with pwm enabled selects 16-bit pwm
// - toggle plus pwm enabled gives frequency output toggling on matches
// - module 5 mode register locked while watchdog enable is set
`timescale 1ns/100ps
`include "ppcm_defines.vh"

module ppcm_pwm_cfg (
	// clock and reset
	input  wire        clk_sys,
	input  wire        reset,
	// sfr bus
	input  wire [7:0]  sfr_addr,
	input  wire        sfr_wr,
	input  wire        sfr_rd,
	input  wire [7:0]  sfr_wdata,
	output reg  [7:0]  sfr_rdata_q,
	output reg         sfr_hit_q,
	// counter array side
	input  wire [15:0] main_counter,
	input  wire        counter_tick,
	input  wire        watchdog_enable_bit,
	// outputs to the array
	output wire        cycle_wrap_irq,
	output reg  [5:0]  module_output_pin_q,
	output wire [5:0]  module_wide_pwm,
	output wire [5:0]  module_freq_out,
	output wire [1:0]  cycle_length_select
);

	// configuration state
	reg [7:0]  mode_q [0:5];
	reg        reload_bank_select_q;
	reg        cycle_wrap_irq_enable_q;
	reg        cycle_wrap_flag_q;
	reg [1:0]  cycle_length_select_q;
	reg [1:0]  rd_kind_q;
	reg [7:0]  rd_direct_q;
	reg        rd_high_q;
	reg        rd_bank_q;
	reg [95:0] reload_q;
	integer    k;

	wire        cycle_wrap_pulse;
	wire        wide_wrap_pulse;
	wire [95:0] cmp_words;
	wire [15:0] cmp_rd;

	// decode of a compare byte address: valid, high, index
	// the offset is worked out at full address width and then cut to three
	// bits, so the valid and high flags keep their places in the result
	function [4:0] ppcm_cmp_dec;
		input [7:0] a;
		reg   [7:0] off;
		begin
			off = 8'h00;
			if ((a >= `PPCM_ADDR_CMPL_BASE) && (a < `PPCM_ADDR_CMPL_BASE + 8'h06)) begin
				off          = a - `PPCM_ADDR_CMPL_BASE;
				ppcm_cmp_dec = {1'b1, 1'b0, off[2:0]};
			end else if ((a >= `PPCM_ADDR_CMPH_BASE) && (a < `PPCM_ADDR_CMPH_BASE + 8'h06)) begin
				off          = a - `PPCM_ADDR_CMPH_BASE;
				ppcm_cmp_dec = {1'b1, 1'b1, off[2:0]};
			end else begin
				ppcm_cmp_dec = 5'h00;
			end
		end
	endfunction

	// mode register index for an address, 7 when none
	function [2:0] ppcm_mode_idx;
		input [7:0] a;
		begin
			case (a)
				`PPCM_ADDR_MODE0: ppcm_mode_idx = 3'h0;
				`PPCM_ADDR_MODE1: ppcm_mode_idx = 3'h1;
				`PPCM_ADDR_MODE2: ppcm_mode_idx = 3'h2;
				`PPCM_ADDR_MODE3: ppcm_mode_idx = 3'h3;
				`PPCM_ADDR_MODE4: ppcm_mode_idx = 3'h4;
				`PPCM_ADDR_MODE5: ppcm_mode_idx = 3'h5;
				default:          ppcm_mode_idx = 3'h7;
			endcase
		end
	endfunction

	wire [4:0] cdec_w    = ppcm_cmp_dec(sfr_addr);
	wire       cmp_hit_w = cdec_w[4];
	wire       cmp_hi_w  = cdec_w[3];
	wire [2:0] cmp_idx_w = cdec_w[2:0];
	wire [2:0] mode_idx_w = ppcm_mode_idx(sfr_addr);
	wire       cfg_hit_w = (sfr_addr == `PPCM_ADDR_PWMCFG);

	// reload words only matter outside 8-bit length
	wire reload_active_w = (cycle_length_select_q != `PPCM_CLSEL_8);

	// pwm cycle config register; set beats software clear of the flag
	always @(posedge clk_sys) begin
		if (reset) begin
			reload_bank_select_q    <= 1'b0;
			cycle_wrap_irq_enable_q <= 1'b0;
			cycle_wrap_flag_q       <= 1'b0;
			cycle_length_select_q   <= `PPCM_CLSEL_8;
		end else begin
			if (sfr_wr && cfg_hit_w) begin
				reload_bank_select_q    <= sfr_wdata[`PPCM_BANK_SEL_BIT];
				cycle_wrap_irq_enable_q <= sfr_wdata[`PPCM_WRAP_IE_BIT];
				cycle_length_select_q   <= sfr_wdata[`PPCM_CLSEL_HI:`PPCM_CLSEL_LO];
			end
			if (cycle_wrap_pulse)
				cycle_wrap_flag_q <= 1'b1;
			else if (sfr_wr && cfg_hit_w)
				cycle_wrap_flag_q <= sfr_wdata[`PPCM_WRAP_FLAG_BIT];
		end
	end

	// interrupt request follows flag and enable
	assign cycle_wrap_irq      = cycle_wrap_flag_q & cycle_wrap_irq_enable_q;
	assign cycle_length_select = cycle_length_select_q;

	// mode registers; module 5 frozen while the watchdog owns it
	always @(posedge clk_sys) begin
		if (reset) begin
			for (k = 0; k < 6; k = k + 1)
				mode_q[k] <= `PPCM_MODE_RESET;
		end else if (sfr_wr && (mode_idx_w != 3'h7)) begin
			if (!((mode_idx_w == 3'h5) && watchdog_enable_bit))
				mode_q[mode_idx_w] <= sfr_wdata;
		end
	end

	// reload words live in flops: copied out to non-wide pwm modules each cycle end outside 8-bit length, too wide for a port
	always @(posedge clk_sys) begin
		if (reset) begin
			reload_q <= 96'h0;
		end else if (sfr_wr && cmp_hit_w && reload_bank_select_q) begin
			if (cmp_hi_w)
				reload_q[cmp_idx_w*16+8 +: 8] <= sfr_wdata;
			else
				reload_q[cmp_idx_w*16 +: 8] <= sfr_wdata;
		end
	end

	// compare write arbitration: software bank 0 first, else cycle-end reload
	reg        cw_en;
	reg        cw_hi;
	reg [2:0]  cw_idx;
	reg [7:0]  cw_data;
	reg [2:0]  reload_ptr_q;
	reg [1:0]  reload_phase_q;
	reg        reload_busy_q;

	always @* begin
		cw_en   = 1'b0;
		cw_hi   = 1'b0;
		cw_idx  = 3'h0;
		cw_data = 8'h00;
		if (sfr_wr && cmp_hit_w && !reload_bank_select_q) begin
			cw_en   = 1'b1;
			cw_hi   = cmp_hi_w;
			cw_idx  = cmp_idx_w;
			cw_data = sfr_wdata;
		end else if (reload_busy_q) begin
			cw_hi   = reload_phase_q[1];
			cw_idx  = reload_ptr_q;
			cw_data = cw_hi ? reload_q[reload_ptr_q*16+8 +: 8]
			                : reload_q[reload_ptr_q*16 +: 8];
			// wide modules keep their own compare word
			cw_en   = mode_q[reload_ptr_q][`PPCM_PULSE_BIT]
			        & ~mode_q[reload_ptr_q][`PPCM_WIDE_BIT];
		end
	end

	// cycle-end walk over the six modules, two bytes each
	// a bank-0 software write stalls the walk for that edge, so the reload byte
	// due then is written on a later edge and not skipped on the shared port
	always @(posedge clk_sys) begin
		if (reset) begin
			reload_busy_q  <= 1'b0;
			reload_ptr_q   <= 3'h0;
			reload_phase_q <= 2'h0;
		end else if (!reload_busy_q) begin
			if (cycle_wrap_pulse && reload_active_w) begin
				reload_busy_q  <= 1'b1;
				reload_ptr_q   <= 3'h0;
				reload_phase_q <= 2'h0;
			end
		end else if (!(sfr_wr && cmp_hit_w && !reload_bank_select_q)) begin
			if (reload_phase_q[1]) begin
				reload_phase_q <= 2'h0;
				if (reload_ptr_q == 3'h5)
					reload_busy_q <= 1'b0;
				else
					reload_ptr_q <= reload_ptr_q + 3'h1;
			end else begin
				reload_phase_q <= 2'h2;
			end
		end
	end

	// read index follows the bus address so the word is ready one edge on
	ppcm_cmp_mem u_cmp (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.wr_en     (cw_en),
		.wr_high   (cw_hi),
		.wr_index  (cw_idx),
		.wr_data   (cw_data),
		.rd_index  (cmp_idx_w),
		.rd_data_q (cmp_rd),
		.all_words (cmp_words)
	);

	ppcm_wrap_det u_wrap (
		.clk_sys             (clk_sys),
		.reset               (reset),
		.main_counter        (main_counter),
		.counter_tick        (counter_tick),
		.cycle_length_select (cycle_length_select_q),
		.cycle_wrap_pulse    (cycle_wrap_pulse),
		.wide_wrap_pulse     (wide_wrap_pulse)
	);

	// read path: stage 1 captures kind and direct data
	always @(posedge clk_sys) begin
		if (reset) begin
			rd_kind_q   <= 2'h0;
			rd_direct_q <= 8'h00;
			rd_high_q   <= 1'b0;
			rd_bank_q   <= 1'b0;
		end else begin
			rd_kind_q   <= 2'h0;
			rd_high_q   <= cmp_hi_w;
			rd_bank_q   <= reload_bank_select_q;
			// reload byte is staged unless a cfg or mode read takes the slot; only a bank-1 compare read uses it
			rd_direct_q <= cmp_hi_w ? reload_q[cmp_idx_w*16+8 +: 8]
			                        : reload_q[cmp_idx_w*16 +: 8];
			if (sfr_rd && cfg_hit_w) begin
				rd_kind_q   <= 2'h1;
				// bits 4 to 2 always zero
				rd_direct_q <= {reload_bank_select_q, cycle_wrap_irq_enable_q,
				                cycle_wrap_flag_q, 3'h0, cycle_length_select_q};
			end else if (sfr_rd && (mode_idx_w != 3'h7)) begin
				rd_kind_q   <= 2'h1;
				rd_direct_q <= mode_q[mode_idx_w];
			end else if (sfr_rd && cmp_hit_w) begin
				rd_kind_q   <= 2'h2;
			end
		end
	end

	// read path: stage 2 picks compare or reload byte
	wire [7:0] cmp_byte_w = rd_high_q ? cmp_rd[15:8] : cmp_rd[7:0];
	always @(posedge clk_sys) begin
		if (reset) begin
			sfr_rdata_q <= 8'h00;
			sfr_hit_q   <= 1'b0;
		end else begin
			sfr_hit_q <= (rd_kind_q != 2'h0);
			case (rd_kind_q)
				2'h1:    sfr_rdata_q <= rd_direct_q;
				2'h2:    sfr_rdata_q <= rd_bank_q ? rd_direct_q : cmp_byte_w;
				default: sfr_rdata_q <= 8'h00;
			endcase
		end
	end

	// per-module mode decode and pin behaviour
	wire [5:0] pin_next_w;
	genvar m;
	generate
		for (m = 0; m < 6; m = m + 1) begin : g_mod
			wire [7:0]  md  = mode_q[m];
			wire [15:0] cw  = cmp_words[m*16 +: 16];
			wire        pwm = md[`PPCM_PULSE_BIT];
			wire        wide = pwm & md[`PPCM_WIDE_BIT];
			wire        freq = pwm & md[`PPCM_TOGGLE_BIT];
			wire [10:0] lmask = (cycle_length_select_q == `PPCM_CLSEL_8)  ? 11'h0FF :
			                    (cycle_length_select_q == `PPCM_CLSEL_9)  ? 11'h1FF :
			                    (cycle_length_select_q == `PPCM_CLSEL_10) ? 11'h3FF :
			                    11'h7FF;
			wire match_w = wide ? (main_counter == cw)
			             : ((main_counter[10:0] & lmask) == (cw[10:0] & lmask));
			assign module_wide_pwm[m] = wide;
			assign module_freq_out[m] = freq;

			// pwm: high from match to cycle end; freq: toggle on match
			wire        wrap_w = wide ? wide_wrap_pulse : cycle_wrap_pulse;
			assign pin_next_w[m] =
				(freq && counter_tick && match_w)    ? ~module_output_pin_q[m] :
				(pwm && counter_tick && match_w)     ? 1'b1 :
				(pwm && !freq && wrap_w)             ? 1'b0 :
				module_output_pin_q[m];
		end
	endgenerate

	// all six pins in one process so the vector has a single driver
	always @(posedge clk_sys) begin
		if (reset)
			module_output_pin_q <= 6'h00;
		else
			module_output_pin_q <= pin_next_w;
	end

endmodule // ppcm_pwm_cfg

// [bench/ppcm_pwm_cfg_checker.sv]
// ppcm_pwm_cfg_checker.sv: port assertions for the pwm cycle config block.
// assumes read data two cycles after the strobe and writes landing next edge.
`timescale 1ns/100ps

module ppcm_pwm_cfg_checker (
	// clock and reset
	input logic       clk_sys,
	input logic       reset,
	// sfr bus
	input logic [7:0] sfr_addr,
	input logic       sfr_wr,
	input logic       sfr_rd,
	input logic [7:0] sfr_wdata,
	input logic [7:0] sfr_rdata_q,
	input logic       sfr_hit_q,
	// array side
	input logic       counter_tick,
	input logic       watchdog_enable_bit,
	input logic       cycle_wrap_irq,
	input logic [5:0] module_wide_pwm,
	input logic [5:0] module_freq_out,
	input logic [1:0] cycle_length_select
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// decoded write strobes
	wire cfg_wr = sfr_wr && sfr_addr == 8'hDF;
	wire m0_wr = sfr_wr && sfr_addr == 8'hDA;

	property p_rd_lat;
		sfr_rd && sfr_addr == 8'hDF |-> ##2 sfr_hit_q && sfr_rdata_q[4:2] == 3'h0;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("cfg read late or reserved bits set");
	property p_len_wr;
		cfg_wr |=> cycle_length_select == $past(sfr_wdata[1:0]);
	endproperty
	a_len_wr: assert property (p_len_wr) else $error("length select not written");
	property p_len_hold;
		!cfg_wr |=> $stable(cycle_length_select);
	endproperty
	a_len_hold: assert property (p_len_hold) else $error("length select moved alone");
	// a wrap needs a recent tick; only software raises it otherwise
	property p_irq_rise;
		$rose(cycle_wrap_irq) |-> $past(cfg_wr) || $past(counter_tick) || $past(counter_tick, 2);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
	property p_irq_fall;
		$fell(cycle_wrap_irq) && !$past(reset) |-> $past(cfg_wr);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq cleared by hardware");
	property p_mode_hold;
		!sfr_wr |=> $stable(module_wide_pwm) && $stable(module_freq_out);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode outputs moved alone");
	property p_wide0;
		m0_wr |=> module_wide_pwm[0] == ($past(sfr_wdata[7]) && $past(sfr_wdata[1]));
	endproperty
	a_wide0: assert property (p_wide0) else $error("wide pwm decode wrong");
	property p_freq0;
		m0_wr |=> module_freq_out[0] == ($past(sfr_wdata[2]) && $past(sfr_wdata[1]));
	endproperty
	a_freq0: assert property (p_freq0) else $error("freq output decode wrong");
	property p_lock5;
		watchdog_enable_bit && sfr_wr && sfr_addr == 8'hCE |=>
			$stable(module_wide_pwm[5]) && $stable(module_freq_out[5]);
	endproperty
	a_lock5: assert property (p_lock5) else $error("module 5 changed while locked");
endmodule // ppcm_pwm_cfg_checker

bind ppcm_pwm_cfg ppcm_pwm_cfg_checker i_chk (.*);

// [bench/ppcm_pwm_cfg_bench.sv]
// ppcm_pwm_cfg_bench.sv: self-checking bench for the pwm cycle config block.
// assumes the sfr bus timing of the block; inputs change on falling edges.
`timescale 1ns/100ps
`include "ppcm_defines.vh"

module ppcm_pwm_cfg_bench;
	reg         clk_sys = 1'b0;
	reg         reset = 1'b1;
	reg  [7:0]  sfr_addr = 8'h00;
	reg         sfr_wr = 1'b0;
	reg         sfr_rd = 1'b0;
	reg  [7:0]  sfr_wdata = 8'h00;
	reg  [15:0] main_counter = 16'h0000;
	reg         counter_tick = 1'b0;
	reg         watchdog_enable_bit = 1'b0;
	wire [7:0]  sfr_rdata_q;
	wire        sfr_hit_q;
	wire        cycle_wrap_irq;
	wire [5:0]  module_wide_pwm;
	wire [5:0]  module_freq_out;
	wire [1:0]  cycle_length_select;
	wire [5:0]  module_output_pin_q;
	integer     bad_count = 0;
	integer     tests_run = 0;
	integer     seed = 32'h75119864;
	integer     i;
	integer     s;
	reg  [7:0]  v;

	ppcm_pwm_cfg i_dut (
		.clk_sys             (clk_sys),
		.reset               (reset),
		.sfr_addr            (sfr_addr),
		.sfr_wr              (sfr_wr),
		.sfr_rd              (sfr_rd),
		.sfr_wdata           (sfr_wdata),
		.sfr_rdata_q         (sfr_rdata_q),
		.sfr_hit_q           (sfr_hit_q),
		.main_counter        (main_counter),
		.counter_tick        (counter_tick),
		.watchdog_enable_bit (watchdog_enable_bit),
		.cycle_wrap_irq      (cycle_wrap_irq),
		.module_output_pin_q (module_output_pin_q),
		.module_wide_pwm     (module_wide_pwm),
		.module_freq_out     (module_freq_out),
		.cycle_length_select (cycle_length_select)
	);

	// 50 MHz system clock
	always #10 clk_sys = ~clk_sys;

	// expectation helpers
	function [7:0] mode_addr(input integer n);
		mode_addr = (n == 5) ? `PPCM_ADDR_MODE5 : `PPCM_ADDR_MODE0 + n[7:0];
	endfunction
	function [7:0] cfg_exp(input [7:0] d);
		cfg_exp = d & 8'hE3;
	endfunction
	function [15:0] wrap_at(input [1:0] sel);
		wrap_at = (16'h0100 << sel) - 16'h0001;
	endfunction

	task check(input [15:0] seen, input [15:0] exp, input string what);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one write strobe, held for a single edge
	task wr(input [7:0] a, input [7:0] d);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk_sys);
		sfr_wr = 1'b0;
	endtask

	// read strobe, then look at hit and data while they stand after the second edge
	task rdchk(input [7:0] a, input [8:0] e, input string what);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk_sys);
		sfr_rd = 1'b0;
		@(negedge clk_sys);
		check({sfr_hit_q, sfr_rdata_q}, e, what);
	endtask

	// one counter advance from the given value
	task wrap(input [15:0] cnt);
		@(negedge clk_sys);
		main_counter = cnt;
		counter_tick = 1'b1;
		@(negedge clk_sys);
		counter_tick = 1'b0;
		main_counter = cnt + 16'h0001;
		repeat (3) @(negedge clk_sys);
	endtask

	// cut a hang short; the whole run needs far fewer cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count = bad_count + 1;
		report_and_stop;
	end

	// main sequence
	initial begin
		repeat (4) @(negedge clk_sys);
		reset = 1'b0;
		for (i = 0; i < 6; i++) rdchk(mode_addr(i), 9'h100, "mode rst");
		rdchk(`PPCM_ADDR_PWMCFG, 9'h100, "cfg rst");
		rdchk(8'h00, 9'h000, "unmapped");
		// mode values, corner first, then random
		for (i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'h86 : $random(seed);
			wr(mode_addr(i), v);
			rdchk(mode_addr(i), {1'b1, v}, "mode rw");
			check(module_wide_pwm[i], v[7] & v[1], "wide");
			check(module_freq_out[i], v[2] & v[1], "freq");
		end
		// module 5 is frozen while the watchdog owns it
		watchdog_enable_bit = 1'b1;
		wr(`PPCM_ADDR_MODE5, ~v);
		rdchk(`PPCM_ADDR_MODE5, {1'b1, v}, "locked");
		watchdog_enable_bit = 1'b0;
		wr(`PPCM_ADDR_MODE5, 8'h00);
		rdchk(`PPCM_ADDR_MODE5, 9'h100, "unlocked");
		// software may set the flag; reserved bits stay zero
		wr(`PPCM_ADDR_PWMCFG, 8'hFF);
		rdchk(`PPCM_ADDR_PWMCFG, {1'b1, cfg_exp(8'hFF)}, "cfg");
		check(cycle_wrap_irq, 1, "irq on");
		wr(`PPCM_ADDR_PWMCFG, 8'h40);
		check(cycle_wrap_irq, 0, "irq clr");
		// each bank keeps its own bytes at the shared addresses
		for (i = 0; i < 12; i++) begin
			v = $random(seed);
			s = (i < 6) ? `PPCM_ADDR_CMPL_BASE + i : `PPCM_ADDR_CMPH_BASE + i - 6;
			wr(`PPCM_ADDR_PWMCFG, 8'h00);
			wr(s[7:0], v);
			wr(`PPCM_ADDR_PWMCFG, 8'h80);
			wr(s[7:0], ~v);
			rdchk(s[7:0], {1'b1, ~v}, "reload");
			wr(`PPCM_ADDR_PWMCFG, 8'h00);
			rdchk(s[7:0], {1'b1, v}, "compare");
		end
		// the flag follows only the carry of the selected bit
		for (s = 0; s < 4; s++) begin
			wr(`PPCM_ADDR_PWMCFG, 8'h40 | s[7:0]);
			check(cycle_length_select, s, "len");
			if (s > 0)
				wrap(wrap_at(s - 1));
			check(cycle_wrap_irq, 0, "early");
			wrap(wrap_at(s));
			check(cycle_wrap_irq, 1, "wrap");
		end
		wr(`PPCM_ADDR_PWMCFG, 8'h01);
		wrap(wrap_at(1));
		check(cycle_wrap_irq, 0, "masked");
		rdchk(`PPCM_ADDR_PWMCFG, 9'h121, "flag");
		// reload reaches the compare word only in the longer cycles
		wr(`PPCM_ADDR_MODE0, 8'h42);
		wr(`PPCM_ADDR_PWMCFG, 8'h80);
		wr(`PPCM_ADDR_CMPL_BASE, 8'h3C);
		wr(`PPCM_ADDR_PWMCFG, 8'h00);
		wr(`PPCM_ADDR_CMPL_BASE, 8'h11);
		wrap(wrap_at(0));
		repeat (20) @(negedge clk_sys);
		rdchk(`PPCM_ADDR_CMPL_BASE, 9'h111, "no reload");
		wr(`PPCM_ADDR_PWMCFG, 8'h01);
		wrap(wrap_at(1));
		repeat (20) @(negedge clk_sys);
		rdchk(`PPCM_ADDR_CMPL_BASE, 9'h13C, "reloaded");
		// a second reset in mid-run clears everything again
		@(negedge clk_sys);
		reset = 1'b1;
		repeat (4) @(negedge clk_sys);
		reset = 1'b0;
		rdchk(`PPCM_ADDR_MODE0, 9'h100, "mode rst2");
		rdchk(`PPCM_ADDR_PWMCFG, 9'h100, "cfg rst2");
		// pins: freq toggles on match; wide pwm ignores the 8-bit length
		wr(`PPCM_ADDR_MODE1, 8'h46);
		wr(`PPCM_ADDR_MODE2, 8'h82);
		wr(`PPCM_ADDR_CMPL_BASE + 8'h01, 8'h20);
		wr(`PPCM_ADDR_CMPL_BASE + 8'h02, 8'h20);
		wr(`PPCM_ADDR_CMPH_BASE + 8'h02, 8'h01);
		wrap(16'h0020);
		check(module_output_pin_q[1], 1, "freq pin");
		check(module_output_pin_q[2], 0, "wide no match");
		wrap(16'h0120);
		check(module_output_pin_q[1], 0, "freq toggle");
		check(module_output_pin_q[2], 1, "wide match");
		wrap(16'hFFFF);
		check(module_output_pin_q[2], 0, "wide wrap");
		report_and_stop;
	end
endmodule // ppcm_pwm_cfg_bench
